// File: hdl/tlw_pkg.sv
// constants, types and register map of the table access unit
package tlw_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DATA_W     = 8;
  localparam int WORD_W     = 16;
  localparam int PTR_W      = 16;
  localparam int INT_AW_DEF = 10;
  localparam int BUS_AW     = 4;
  localparam int INT_N      = 4;
  localparam int CORE_N     = 3;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [BUS_AW-1:0] REG_PTR_LO = 4'h0;
  localparam logic [BUS_AW-1:0] REG_PTR_HI = 4'h1;
  localparam logic [BUS_AW-1:0] REG_LAT_LO = 4'h2;
  localparam logic [BUS_AW-1:0] REG_LAT_HI = 4'h3;
  localparam logic [BUS_AW-1:0] REG_INT_EN = 4'h4;
  localparam logic [BUS_AW-1:0] REG_INT_FL = 4'h5;
  localparam logic [BUS_AW-1:0] REG_CTRL   = 4'h6;
  localparam logic [BUS_AW-1:0] REG_STATUS = 4'h7;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int IRQ_TIMER_CLK = 0;
  localparam int IRQ_EXT_PIN   = 1;
  localparam int IRQ_TMR_OVF   = 2;
  localparam int IRQ_PERIPH    = 3;
  localparam int CTRL_GID_BIT  = 0;
  localparam int STAT_HALT_BIT = 0;
  localparam int STAT_GCAP_BIT = 1;

  // ---------------------------------------------------------------
  // reset values and operand codes
  // ---------------------------------------------------------------
  localparam logic [PTR_W-1:0]  PTR_RST  = 16'h0000;
  localparam logic [WORD_W-1:0] LAT_RST  = 16'h0000;
  localparam logic [INT_N-1:0]  EN_RST   = 4'h0;
  localparam logic [INT_N-1:0]  FLAG_RST = 4'h0;
  localparam logic              GID_RST  = 1'b0;
  localparam logic              HALF_HI  = 1'b1;
  localparam logic              INC_ON   = 1'b1;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

  typedef enum logic [1:0] {
    OP_LATCH_WRITE,
    OP_TABLE_WRITE,
    OP_LATCH_READ,
    OP_TABLE_READ
  } tlw_op_t;

endpackage

// File: hdl/tlw_prog_mem.sv
// program memory array with registered read data
`timescale 1ns/1ps
module tlw_prog_mem #(
  parameter int AW = 10,
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_r
);

  logic [DW-1:0] cells [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      cells[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= '0;
    end else if (re) begin
      rdata_r <= cells[raddr];
    end
  end

endmodule

// File: hdl/tlw_table_access.sv
// table access unit with long write control
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module tlw_table_access
  import tlw_pkg::*;
#(
  parameter int INT_AW = INT_AW_DEF
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [BUS_AW-1:0] bus_addr,
  input  wire logic [DATA_W-1:0] bus_wdata,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output logic      [DATA_W-1:0] bus_rdata_r,
  input  wire logic              insn_valid,
  input  wire tlw_op_t           insn_op,
  input  wire logic              insn_half,
  input  wire logic              insn_inc,
  input  wire logic [DATA_W-1:0] insn_data,
  output logic                   insn_ready_r,
  output logic                   rd_valid_r,
  output logic      [DATA_W-1:0] rd_data_r,
  input  wire logic              irq_timer_clk,
  input  wire logic              irq_ext_pin,
  input  wire logic              irq_tmr_ovf,
  input  wire logic              irq_periph,
  output logic                   long_write_r,
  output logic                   resume_vector_r,
  output logic                   resume_next_r,
  output logic                   ext_wr_r,
  output logic                   ext_rd_r,
  output logic      [PTR_W-1:0]  ext_addr_r,
  output logic      [WORD_W-1:0] ext_wdata_r,
  input  wire logic [WORD_W-1:0] ext_rdata
);

  // ---------------------------------------------------------------
  // state and storage
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_LONG
  } tlw_state_t;

  tlw_state_t        state_r;
  tlw_state_t        state_nxt;
  logic [PTR_W-1:0]  ptr_r;
  logic [PTR_W-1:0]  ptr_nxt;
  logic [WORD_W-1:0] lat_r;
  logic [WORD_W-1:0] lat_nxt;
  logic [INT_N-1:0]  int_en_r;
  logic [INT_N-1:0]  int_flag_r;
  logic [INT_N-1:0]  int_flag_nxt;
  logic              gid_r;
  logic              gid_cap_r;
  logic              rd_half_r;
  logic              rd_int_r;
  logic [WORD_W-1:0] mem_rdata;
  logic [WORD_W-1:0] fill_word;
  logic [INT_N-1:0]  irq_set;
  logic [INT_N-1:0]  bus_clr;
  logic [INT_N-1:0]  auto_clr;
  logic [INT_N-1:0]  pending;
  logic              accept;
  logic              is_int;
  logic              term;
  logic              tw_int;
  logic              bus_wsel;

  assign accept   = insn_valid && insn_ready_r;
  assign is_int   = (ptr_r >> INT_AW) == '0;
  assign tw_int   = accept && (insn_op == OP_TABLE_WRITE) && is_int;
  assign irq_set  = {irq_periph, irq_tmr_ovf, irq_ext_pin, irq_timer_clk};
  assign pending  = int_en_r & int_flag_r;
  assign term     = (state_r == ST_LONG) && (pending != '0);
  assign fill_word = rd_int_r ? mem_rdata : ext_rdata;
  assign bus_wsel = bus_wr;

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (tw_int) begin
          state_nxt = ST_LONG;
        end else if (accept && insn_op == OP_TABLE_READ) begin
          state_nxt = ST_READ;
        end
      end
      ST_READ: begin
        state_nxt = ST_IDLE;
      end
      ST_LONG: begin
        if (term) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r      <= ST_IDLE;
      insn_ready_r <= 1'b0;
      long_write_r <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      insn_ready_r <= state_nxt == ST_IDLE;
      long_write_r <= state_nxt == ST_LONG;
    end
  end

  // ---------------------------------------------------------------
  // table latch and pointer
  // ---------------------------------------------------------------
  always_comb begin
    lat_nxt = lat_r;
    if (state_r == ST_READ) begin
      lat_nxt = fill_word;
    end else if (accept && (insn_op == OP_LATCH_WRITE || insn_op == OP_TABLE_WRITE)) begin
      if (insn_half == HALF_HI) begin
        lat_nxt[WORD_W-1:DATA_W] = insn_data;
      end else begin
        lat_nxt[DATA_W-1:0] = insn_data;
      end
    end else if (bus_wsel && bus_addr == REG_LAT_LO) begin
      lat_nxt[DATA_W-1:0] = bus_wdata;
    end else if (bus_wsel && bus_addr == REG_LAT_HI) begin
      lat_nxt[WORD_W-1:DATA_W] = bus_wdata;
    end
  end

  always_comb begin
    ptr_nxt = ptr_r;
    if (accept && (insn_op == OP_TABLE_WRITE || insn_op == OP_TABLE_READ)) begin
      if (insn_inc == INC_ON) begin
        ptr_nxt = ptr_r + 1'b1;
      end
    end else if (bus_wsel && bus_addr == REG_PTR_LO) begin
      ptr_nxt[DATA_W-1:0] = bus_wdata;
    end else if (bus_wsel && bus_addr == REG_PTR_HI) begin
      ptr_nxt[PTR_W-1:DATA_W] = bus_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lat_r <= LAT_RST;
      ptr_r <= PTR_RST;
    end else begin
      lat_r <= lat_nxt;
      ptr_r <= ptr_nxt;
    end
  end

  // ---------------------------------------------------------------
  // program memory and external accesses
  // ---------------------------------------------------------------
  tlw_prog_mem #(
    .AW (INT_AW),
    .DW (WORD_W)
  ) u_mem (
    .clk     (clk),
    .reset   (reset),
    .we      (tw_int),
    .waddr   (ptr_r[INT_AW-1:0]),
    .wdata   (lat_nxt),
    .re      (accept && insn_op == OP_TABLE_READ),
    .raddr   (ptr_r[INT_AW-1:0]),
    .rdata_r (mem_rdata)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      ext_wr_r    <= 1'b0;
      ext_rd_r    <= 1'b0;
      ext_addr_r  <= PTR_RST;
      ext_wdata_r <= LAT_RST;
      rd_half_r   <= 1'b0;
      rd_int_r    <= 1'b0;
    end else begin
      ext_wr_r <= accept && insn_op == OP_TABLE_WRITE && !is_int;
      ext_rd_r <= accept && insn_op == OP_TABLE_READ && !is_int;
      if (accept && (insn_op == OP_TABLE_WRITE || insn_op == OP_TABLE_READ)) begin
        ext_addr_r  <= ptr_r;
        ext_wdata_r <= lat_nxt;
        rd_half_r   <= insn_half;
        rd_int_r    <= is_int;
      end
    end
  end

  // ---------------------------------------------------------------
  // byte results to the data registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_valid_r <= 1'b0;
      rd_data_r  <= BYTE_ZERO;
    end else begin
      rd_valid_r <= 1'b0;
      if (accept && insn_op == OP_LATCH_READ) begin
        rd_valid_r <= 1'b1;
        rd_data_r  <= (insn_half == HALF_HI) ? lat_r[WORD_W-1:DATA_W] : lat_r[DATA_W-1:0];
      end else if (state_r == ST_READ) begin
        rd_valid_r <= 1'b1;
        rd_data_r  <= (rd_half_r == HALF_HI) ? fill_word[WORD_W-1:DATA_W] : fill_word[DATA_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt flags and long write termination
  // ---------------------------------------------------------------
  always_comb begin
    auto_clr = '0;
    if (term) begin
      for (int i = CORE_N - 1; i >= 0; i--) begin
        if (pending[i]) begin
          auto_clr = '0;
          auto_clr[i] = 1'b1;
        end
      end
    end
  end

  assign bus_clr = (bus_wsel && bus_addr == REG_INT_FL) ? bus_wdata[INT_N-1:0] : '0;
  // set beats any clear in the same cycle; peripheral bit only cleared by software
  assign int_flag_nxt = (int_flag_r & ~(bus_clr | auto_clr)) | irq_set;

  always_ff @(posedge clk) begin
    if (reset) begin
      int_flag_r <= FLAG_RST;
      int_en_r   <= EN_RST;
      gid_r      <= GID_RST;
      gid_cap_r  <= GID_RST;
    end else begin
      int_flag_r <= int_flag_nxt;
      if (bus_wsel && bus_addr == REG_INT_EN) begin
        int_en_r <= bus_wdata[INT_N-1:0];
      end
      if (bus_wsel && bus_addr == REG_CTRL) begin
        gid_r <= bus_wdata[CTRL_GID_BIT];
      end
      if (tw_int) begin
        gid_cap_r <= gid_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      resume_vector_r <= 1'b0;
      resume_next_r   <= 1'b0;
    end else begin
      resume_vector_r <= term && !gid_cap_r;
      resume_next_r   <= term && gid_cap_r;
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_rdata_r <= BYTE_ZERO;
    end else begin
      bus_rdata_r <= BYTE_ZERO;
      if (bus_rd) begin
        unique case (bus_addr)
          REG_PTR_LO: bus_rdata_r <= ptr_r[DATA_W-1:0];
          REG_PTR_HI: bus_rdata_r <= ptr_r[PTR_W-1:DATA_W];
          REG_LAT_LO: bus_rdata_r <= lat_r[DATA_W-1:0];
          REG_LAT_HI: bus_rdata_r <= lat_r[WORD_W-1:DATA_W];
          REG_INT_EN: bus_rdata_r <= {{(DATA_W-INT_N){1'b0}}, int_en_r};
          REG_INT_FL: bus_rdata_r <= {{(DATA_W-INT_N){1'b0}}, int_flag_r};
          REG_CTRL:   bus_rdata_r[CTRL_GID_BIT] <= gid_r;
          REG_STATUS: begin
            bus_rdata_r[STAT_HALT_BIT] <= state_r == ST_LONG;
            bus_rdata_r[STAT_GCAP_BIT] <= gid_cap_r;
          end
          default:    bus_rdata_r <= BYTE_ZERO;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_latch_write_half: assert property (
    accept && insn_op == OP_LATCH_WRITE && insn_half == HALF_HI
    |=> lat_r[WORD_W-1:DATA_W] == $past(insn_data) && lat_r[DATA_W-1:0] == $past(lat_r[DATA_W-1:0])
  ) else $error("latch write touched wrong byte");

  a_table_write_mem: assert property (
    tw_int |=> u_mem.cells[$past(ptr_r[INT_AW-1:0])] == lat_r && long_write_r && !insn_ready_r
  ) else $error("table write did not store latch and halt");

  a_ptr_step: assert property (
    accept && (insn_op == OP_TABLE_WRITE || insn_op == OP_TABLE_READ)
    |=> ptr_r == $past(ptr_r) + (($past(insn_inc) == INC_ON) ? 16'h0001 : 16'h0000)
  ) else $error("table pointer step wrong");

  a_latch_read_byte: assert property (
    accept && insn_op == OP_LATCH_READ && insn_half != HALF_HI
    |=> rd_valid_r && rd_data_r == $past(lat_r[DATA_W-1:0])
  ) else $error("latch read returned wrong byte");

  a_table_read_fill: assert property (
    accept && insn_op == OP_TABLE_READ |=> !rd_valid_r ##1 rd_valid_r && lat_r == $past(fill_word)
  ) else $error("table read did not fill latch");

  a_long_hold: assert property (
    long_write_r && !term |=> long_write_r [*1] ##0 !resume_vector_r && !resume_next_r
  ) else $error("long write ended without interrupt");

  a_term_needs_both: assert property (
    state_r == ST_LONG && pending == '0 |=> state_r == ST_LONG
  ) else $error("long write ended without enabled flag");

  a_core_autoclr: assert property (
    term && auto_clr != '0 && (irq_set & auto_clr) == '0 |=> (int_flag_r & $past(auto_clr)) == '0
  ) else $error("core flag not auto-cleared");

  a_periph_keep: assert property (
    term && int_flag_r[IRQ_PERIPH] && !bus_clr[IRQ_PERIPH] |=> int_flag_r[IRQ_PERIPH]
  ) else $error("peripheral flag lost at termination");

  a_gid_no_vector: assert property (
    term && gid_cap_r |=> !resume_vector_r && resume_next_r && insn_ready_r
  ) else $error("vectored with global disable set");

  a_end_resumes: assert property (
    term |=> !long_write_r && (resume_vector_r ^ resume_next_r)
  ) else $error("long write end not signalled");

  c_long_vector:  cover property (tw_int ##[1:50] resume_vector_r);
  c_long_next:    cover property (tw_int ##[1:50] resume_next_r);
  c_table_read:   cover property (accept && insn_op == OP_TABLE_READ ##2 rd_valid_r);
  c_periph_end:   cover property (term && pending == (4'h1 << IRQ_PERIPH));

endmodule

// File: test/tlw_ext_mem.sv
// external program memory model answering table reads and writes
`timescale 1ns/1ps
module tlw_ext_mem
  import tlw_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              ext_wr,
  input  wire logic              ext_rd,
  input  wire logic [PTR_W-1:0]  ext_addr,
  input  wire logic [WORD_W-1:0] ext_wdata,
  output logic      [WORD_W-1:0] ext_rdata
);
  logic [WORD_W-1:0] mem_r [256];
  logic [WORD_W-1:0] last_r = 16'hC35A;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ext_wr) begin
      mem_r[ext_addr[7:0]] <= ext_wdata;
    end
    last_r <= ext_rdata;
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // outside a read the word toggles, never a stale copy
  assign ext_rdata = ext_rd ? mem_r[ext_addr[7:0]] : ~last_r;
endmodule

// File: test/tlw_table_access_bench.sv
// self-checking bench of the table access unit
`timescale 1ns/1ps
module tlw_table_access_bench
  import tlw_pkg::*;
;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic [BUS_AW-1:0] bus_addr = 4'h0;
  logic [DATA_W-1:0] bus_wdata = 8'h00;
  logic              bus_wr = 1'b0;
  logic              bus_rd = 1'b0;
  logic [DATA_W-1:0] bus_rdata_r;
  logic              insn_valid = 1'b0;
  tlw_op_t           insn_op = OP_LATCH_WRITE;
  logic              insn_half = 1'b0;
  logic              insn_inc = 1'b0;
  logic [DATA_W-1:0] insn_data = 8'h00;
  logic              insn_ready_r, rd_valid_r, long_write_r, resume_vector_r, resume_next_r;
  logic [DATA_W-1:0] rd_data_r;
  logic [3:0]        irq = 4'h0;
  logic              ext_wr_r, ext_rd_r;
  logic [PTR_W-1:0]  ext_addr_r;
  logic [WORD_W-1:0] ext_wdata_r, ext_rdata;
  int                failures = 0;
  int                n_compared = 0;
  logic [7:0]        v;

  always #5 clk = ~clk;

  tlw_table_access #(.INT_AW(4)) dut_u (
    .clk(clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata_r(bus_rdata_r), .insn_valid(insn_valid), .insn_op(insn_op),
    .insn_half(insn_half), .insn_inc(insn_inc), .insn_data(insn_data), .insn_ready_r(insn_ready_r),
    .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .irq_timer_clk(irq[0]), .irq_ext_pin(irq[1]),
    .irq_tmr_ovf(irq[2]), .irq_periph(irq[3]), .long_write_r(long_write_r),
    .resume_vector_r(resume_vector_r), .resume_next_r(resume_next_r), .ext_wr_r(ext_wr_r),
    .ext_rd_r(ext_rd_r), .ext_addr_r(ext_addr_r), .ext_wdata_r(ext_wdata_r), .ext_rdata(ext_rdata)
  );

  tlw_ext_mem ext_u (
    .clk(clk), .ext_wr(ext_wr_r), .ext_rd(ext_rd_r), .ext_addr(ext_addr_r),
    .ext_wdata(ext_wdata_r), .ext_rdata(ext_rdata)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata_r;
  endtask

  // returns at the edge that takes the instruction
  task automatic insn(input tlw_op_t op, input logic half, input logic inc, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (insn_ready_r !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(insn_ready_r, 1'b1);
    @(posedge clk);
    insn_valid <= 1'b1;
    insn_op <= op;
    insn_half <= half;
    insn_inc <= inc;
    insn_data <= d;
    @(posedge clk);
    insn_valid <= 1'b0;
  endtask

  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    irq <= m;
    @(posedge clk);
    irq <= 4'h0;
  endtask

  task automatic lw_case(input logic [3:0] en, input logic [3:0] pre, input logic [3:0] trig,
                         input logic [3:0] exp_fl, input logic gid, input logic [7:0] p,
                         input logic [7:0] d);
    int n;
    wr(REG_INT_EN, 8'h00);
    wr(REG_INT_FL, 8'h0F);
    wr(REG_INT_EN, {4'h0, en});
    wr(REG_CTRL, {7'h0, gid});
    wr(REG_PTR_LO, p);
    insn(OP_TABLE_WRITE, 1'b0, 1'b1, d);
    #1 chk(long_write_r, 1'b1);
    chk(insn_ready_r, 1'b0);
    pulse(pre);
    repeat (10) @(posedge clk);
    #1 chk(long_write_r, 1'b1);
    rd(REG_STATUS, v);
    chk(v, {6'h0, gid, 1'b1});
    pulse(trig);
    #1 n = 0;
    while (long_write_r !== 1'b0 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(long_write_r, 1'b0);
    chk(resume_vector_r, !gid);
    chk(resume_next_r, gid);
    rd(REG_INT_FL, v);
    chk(v, {4'h0, exp_fl});
    rd(REG_PTR_LO, v);
    chk(v, p + 8'h01);
    wr(REG_PTR_LO, p);
    insn(OP_TABLE_READ, 1'b0, 1'b0, 8'h00);
    @(posedge clk);
    #1 chk(rd_valid_r, 1'b1);
    chk(rd_data_r, d);
    rd(REG_PTR_LO, v);
    chk(v, p);
  endtask

  task automatic tally_and_finish;
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish;
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    wr(REG_PTR_HI, 8'h00);
    insn(OP_LATCH_WRITE, HALF_HI, 1'b0, 8'h12);
    insn(OP_LATCH_WRITE, 1'b0, 1'b0, 8'h34);
    rd(REG_LAT_HI, v);
    chk(v, 8'h12);
    rd(REG_LAT_LO, v);
    chk(v, 8'h34);
    for (int h = 0; h < 2; h++) begin
      insn(OP_LATCH_READ, h[0], 1'b0, 8'h00);
      #1 chk(rd_valid_r, 1'b1);
      chk(rd_data_r, h[0] ? 8'h12 : 8'h34);
    end
    // long writes: enables, pending flags, trigger, expected flags
    lw_case(4'h1, 4'hE, 4'h1, 4'hE, 1'b0, 8'h03, 8'hAB);
    lw_case(4'h6, 4'h9, 4'h6, 4'hD, 1'b0, 8'h07, 8'h5C);
    lw_case(4'h8, 4'h7, 4'h8, 4'hF, 1'b1, 8'h0E, 8'hC1);
    lw_case(4'hF, 4'h0, 4'hC, 4'h8, 1'b1, 8'h0F, 8'h3D);
    // external word: no halt, word leaves as one 16-bit value
    wr(REG_PTR_LO, 8'h00);
    wr(REG_PTR_HI, 8'h01);
    insn(OP_LATCH_WRITE, 1'b0, 1'b0, 8'h34);
    insn(OP_TABLE_WRITE, HALF_HI, 1'b0, 8'h9A);
    #1 chk(ext_wr_r, 1'b1);
    chk(long_write_r, 1'b0);
    chk(ext_addr_r, 16'h0100);
    chk(ext_wdata_r, 16'h9A34);
    insn(OP_LATCH_WRITE, 1'b0, 1'b0, 8'h77);
    insn(OP_TABLE_READ, HALF_HI, INC_ON, 8'h00);
    #1 chk(ext_rd_r, 1'b1);
    @(posedge clk);
    #1 chk(rd_data_r, 8'h9A);
    rd(REG_LAT_LO, v);
    chk(v, 8'h34);
    rd(REG_PTR_LO, v);
    chk(v, 8'h01);
    // reset ends a long write
    wr(REG_PTR_HI, 8'h00);
    wr(REG_INT_EN, 8'h00);
    insn(OP_TABLE_WRITE, 1'b0, 1'b0, 8'h11);
    repeat (5) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1 chk(long_write_r, 1'b0);
    wr(4'hA, 8'hFF);
    for (int a = 0; a < 11; a++) begin
      rd(a[3:0], v);
      chk(v, 8'h00);
    end
    insn(OP_LATCH_READ, 1'b0, 1'b0, 8'h00);
    #1 chk(rd_valid_r, 1'b1);
    tally_and_finish;
  end
endmodule
